// ===== npe_ctrl.v
// Purpose: nvm read/erase/program control with APB registers
// Assumes: array interface runs on pclk, mem_done is one pulse
// Notes:   registers are at most 8 bits wide, in the low byte of each word
`timescale 1ns/10ps
`default_nettype none
`include "npe_map.vh"
module npe_ctrl #(
  parameter AW = 8
) (
  // apb clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // array side
  output reg           mem_rd,
  output reg           mem_wr,
  output reg  [1:0]    mem_space,
  output reg  [1:0]    mem_op,
  output wire [14:0]   mem_addr,
  output wire [13:0]   mem_wdata,
  input  wire [13:0]   mem_rdata,
  input  wire          mem_done,
  input  wire          mem_fail,
  // processor and interrupt
  output wire          cpu_stall,
  output wire          irq
);

  // unlock sequence states
  localparam [1:0] UL_IDLE = 2'd0;
  localparam [1:0] UL_KEY1 = 2'd1;
  localparam [1:0] UL_OPEN = 2'd2;

  // write engine states
  localparam [1:0] WS_IDLE = 2'd0;
  localparam [1:0] WS_ISSUE = 2'd1;
  localparam [1:0] WS_WAIT = 2'd2;

  // register state
  reg        pgd_ff;
  reg        cfg_ff;
  reg        latch_only_load_ff;
  reg        free_ff;
  reg        err_ff;
  reg        program_erase_enable_ff;
  reg        wr_ff;
  reg        rd_ff;
  reg [7:0]  adrl_ff;
  reg [6:0]  adrh_ff;
  reg [7:0]  datl_ff;
  reg [5:0]  dath_ff;
  reg [1:0]  ul_ff;
  reg [1:0]  ws_ff;
  reg [1:0]  irqst_ff;
  reg [1:0]  irqmsk_ff;

  // next values
  reg        nxt_pgd;
  reg        nxt_cfg;
  reg        nxt_latch_only_load;
  reg        nxt_free;
  reg        nxt_err;
  reg        nxt_program_erase_enable;
  reg        nxt_wr;
  reg        nxt_rd;
  reg [7:0]  nxt_adrl;
  reg [6:0]  nxt_adrh;
  reg [7:0]  nxt_datl;
  reg [5:0]  nxt_dath;
  reg [1:0]  nxt_ul;
  reg [1:0]  nxt_ws;
  reg [1:0]  nxt_irqst;
  reg [1:0]  nxt_irqmsk;
  reg        nxt_mem_rd;
  reg        nxt_mem_wr;
  reg [1:0]  nxt_space;
  reg [1:0]  nxt_op;
  reg [31:0] nxt_prdata;

  // decoded bus events
  wire       setup_ph;
  wire       acc_done;
  wire       wr_acc;
  wire       rd_acc;
  wire       mapped;
  wire [7:0] wbyte;
  wire [14:0] full_addr;
  wire [1:0] sel_space;
  wire       start_ok;
  wire       wr_try;
  wire       cfg_rd_ok;
  wire       cfg_wr_ok;
  wire       eng_done;

  // address lies in an inclusive window
  function in_range;
    input [14:0] a;
    input [14:0] lo;
    input [14:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // matches a register offset
  function hit;
    input [AW-1:0] a;
    input [7:0]    off;
    begin
      hit = (a == off[AW-1:0]);
    end
  endfunction

  // apb handshake: zero wait states
  assign setup_ph = psel & ~penable;
  assign acc_done = psel & penable;
  assign pready   = acc_done;
  assign wr_acc   = acc_done & pwrite;
  assign rd_acc   = acc_done & ~pwrite;
  assign wbyte    = pwdata[7:0];

  // only the eight offsets answer without error
  assign mapped = hit(paddr, `NPE_OFF_CTRL)  | hit(paddr, `NPE_OFF_UNLOCK) |
                  hit(paddr, `NPE_OFF_ADRL)  | hit(paddr, `NPE_OFF_ADRH)   |
                  hit(paddr, `NPE_OFF_DATL)  | hit(paddr, `NPE_OFF_DATH)   |
                  hit(paddr, `NPE_OFF_IRQST) | hit(paddr, `NPE_OFF_IRQMSK);
  assign pslverr = acc_done & ~mapped;

  // array address and write data straight from the registers
  assign full_addr = {adrh_ff, adrl_ff};
  assign mem_addr  = full_addr;
  assign mem_wdata = {dath_ff, datl_ff};

  // space routing from the select bits
  assign sel_space = cfg_ff ? `NPE_SP_CFG :          // RULE2
                     (pgd_ff ? `NPE_SP_PGM : `NPE_SP_EE); // RULE1

  // config window permissions
  assign cfg_rd_ok = in_range(full_addr, `NPE_CFG_UID_LO, `NPE_CFG_UID_HI) |
                     in_range(full_addr, `NPE_CFG_RD_LO, `NPE_CFG_RD_HI); // RULE16
  assign cfg_wr_ok = in_range(full_addr, `NPE_CFG_UID_LO, `NPE_CFG_UID_HI); // RULE16

  // any software attempt to set the write strobe
  assign wr_try = wr_acc & hit(paddr, `NPE_OFF_CTRL) & wbyte[`NPE_B_WR];

  // a proper start: unlocked, enabled, idle, writable target
  assign start_ok = wr_try & (ul_ff == UL_OPEN) &      // RULE18
                    wbyte[`NPE_B_PROGRAM_ERASE_ENABLE] &                // RULE9
                    ~wr_ff & ~rd_ff &
                    (~cfg_ff | cfg_wr_ok);              // RULE16

  // array finished the running operation
  assign eng_done = (ws_ff == WS_WAIT) & mem_done;

  // processor halts during program and config space writes
  assign cpu_stall = wr_ff & (mem_space != `NPE_SP_EE); // RULE17

  // masked status drives the interrupt line
  assign irq = |(irqst_ff & irqmsk_ff);

  // unlock tracker: no storage of the written value
  always @* begin
    nxt_ul = ul_ff;
    if (acc_done) begin
      if (wr_acc && hit(paddr, `NPE_OFF_UNLOCK) && wbyte == `NPE_KEY1) begin
        nxt_ul = UL_KEY1; // RULE14
      end else if (wr_acc && hit(paddr, `NPE_OFF_UNLOCK) &&
                   wbyte == `NPE_KEY2 && ul_ff == UL_KEY1) begin
        nxt_ul = UL_OPEN; // RULE13
      end else begin
        nxt_ul = UL_IDLE; // RULE18
      end
    end
  end

  // control, address and data register next values
  always @* begin
    nxt_pgd    = pgd_ff;
    nxt_cfg    = cfg_ff;
    nxt_latch_only_load   = latch_only_load_ff;
    nxt_free   = free_ff;
    nxt_err    = err_ff;
    nxt_program_erase_enable   = program_erase_enable_ff;
    nxt_wr     = wr_ff;
    nxt_rd     = rd_ff;
    nxt_adrl   = adrl_ff;
    nxt_adrh   = adrh_ff;
    nxt_datl   = datl_ff;
    nxt_dath   = dath_ff;
    nxt_irqmsk = irqmsk_ff;
    // software writes
    if (wr_acc) begin
      if (hit(paddr, `NPE_OFF_CTRL)) begin
        nxt_pgd  = wbyte[`NPE_B_PGD];
        nxt_cfg  = wbyte[`NPE_B_CFG];
        nxt_latch_only_load = wbyte[`NPE_B_LATCH_ONLY_LOAD];
        nxt_free = wbyte[`NPE_B_FREE];
        nxt_err  = wbyte[`NPE_B_ERR];
        nxt_program_erase_enable = wbyte[`NPE_B_PROGRAM_ERASE_ENABLE];
        if (wbyte[`NPE_B_RD] && !wr_ff) begin
          nxt_rd = 1'b1; // RULE12
        end
      end else if (hit(paddr, `NPE_OFF_ADRL)) begin
        nxt_adrl = wbyte;
      end else if (hit(paddr, `NPE_OFF_ADRH)) begin
        nxt_adrh = wbyte[6:0];
      end else if (hit(paddr, `NPE_OFF_DATL)) begin
        nxt_datl = wbyte;
      end else if (hit(paddr, `NPE_OFF_DATH)) begin
        nxt_dath = wbyte[5:0];
      end else if (hit(paddr, `NPE_OFF_IRQMSK)) begin
        nxt_irqmsk = wbyte[1:0];
      end
    end
    // one-cycle read: capture array data and drop the strobe
    if (rd_ff) begin
      nxt_rd = 1'b0; // RULE12
      if (cfg_ff && !cfg_rd_ok) begin
        nxt_datl = 8'h00; // RULE15
        nxt_dath = 6'h00; // RULE15
      end else begin
        nxt_datl = mem_rdata[7:0];
        nxt_dath = mem_rdata[13:8];
      end
    end
    // completion of a write clears the strobe, and the erase bit after an erase
    if (eng_done) begin
      nxt_wr = 1'b0; // RULE10
      if (mem_op == `NPE_OP_ERASE && !(wr_acc && hit(paddr, `NPE_OFF_CTRL) &&
          wbyte[`NPE_B_FREE])) begin
        nxt_free = 1'b0; // RULE6
      end
      if (!mem_fail && !wr_try) begin
        nxt_err = 1'b0; // RULE8
      end else if (mem_fail) begin
        nxt_err = 1'b1; // RULE8
      end
    end
    // a strobe set attempt flags the error; start sets the strobe
    if (wr_try) begin
      nxt_err = 1'b1; // RULE8
    end
    if (start_ok) begin
      nxt_wr = 1'b1; // RULE10 RULE11
    end
  end

  // operation selection at the start of a write
  always @* begin
    nxt_space = mem_space;
    nxt_op    = mem_op;
    if (start_ok) begin
      nxt_space = sel_space;
      if (sel_space == `NPE_SP_EE) begin
        nxt_op = `NPE_OP_EEWR; // RULE5 RULE7
      end else if (free_ff) begin
        nxt_op = `NPE_OP_ERASE; // RULE6
      end else if (latch_only_load_ff) begin
        nxt_op = `NPE_OP_LATCH; // RULE3
      end else begin
        nxt_op = `NPE_OP_PROG; // RULE4
      end
    end else if (rd_ff) begin
      nxt_space = sel_space;
    end else if (wr_acc && hit(paddr, `NPE_OFF_CTRL) && wbyte[`NPE_B_RD] &&
                 !wr_ff) begin
      nxt_space = wbyte[`NPE_B_CFG] ? `NPE_SP_CFG :
                  (wbyte[`NPE_B_PGD] ? `NPE_SP_PGM : `NPE_SP_EE);
    end
  end

  // write engine: issue one request, wait for the array
  always @* begin
    nxt_ws     = ws_ff;
    nxt_mem_wr = 1'b0;
    case (ws_ff)
      WS_IDLE: begin
        if (start_ok) begin
          nxt_ws = WS_ISSUE; // RULE10
        end
      end
      WS_ISSUE: begin
        nxt_mem_wr = 1'b1;
        nxt_ws     = WS_WAIT;
      end
      WS_WAIT: begin
        if (mem_done) begin
          nxt_ws = WS_IDLE;
        end
      end
      default: begin
        nxt_ws = WS_IDLE;
      end
    endcase
  end

  // read request pulse follows the strobe
  always @* begin
    nxt_mem_rd = 1'b0;
    if (wr_acc && hit(paddr, `NPE_OFF_CTRL) && wbyte[`NPE_B_RD] &&
        !wr_ff && !rd_ff) begin
      nxt_mem_rd = 1'b1; // RULE12
    end
  end

  // sticky status: hardware set wins over clear on read
  always @* begin
    nxt_irqst = irqst_ff;
    if (rd_acc && hit(paddr, `NPE_OFF_IRQST)) begin
      nxt_irqst = 2'b00;
    end
    if (eng_done && mem_space == `NPE_SP_EE) begin
      nxt_irqst[`NPE_I_WDONE] = 1'b1; // RULE19
    end
    if ((eng_done && mem_fail) || (wr_try && !start_ok)) begin
      nxt_irqst[`NPE_I_ERR] = 1'b1;
    end
  end

  // read data prepared in the setup phase
  always @* begin
    nxt_prdata = prdata;
    if (setup_ph && !pwrite) begin
      nxt_prdata = 32'h0000_0000;
      if (hit(paddr, `NPE_OFF_CTRL)) begin
        nxt_prdata[7:0] = {pgd_ff, cfg_ff, latch_only_load_ff, free_ff,
                           err_ff, program_erase_enable_ff, wr_ff, rd_ff};
      end else if (hit(paddr, `NPE_OFF_ADRL)) begin
        nxt_prdata[7:0] = adrl_ff;
      end else if (hit(paddr, `NPE_OFF_ADRH)) begin
        nxt_prdata[6:0] = adrh_ff;
      end else if (hit(paddr, `NPE_OFF_DATL)) begin
        nxt_prdata[7:0] = datl_ff;
      end else if (hit(paddr, `NPE_OFF_DATH)) begin
        nxt_prdata[5:0] = dath_ff;
      end else if (hit(paddr, `NPE_OFF_IRQST)) begin
        nxt_prdata[1:0] = irqst_ff;
      end else if (hit(paddr, `NPE_OFF_IRQMSK)) begin
        nxt_prdata[1:0] = irqmsk_ff;
      end
    end
  end

  // state registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgd_ff    <= 1'b0;
      cfg_ff    <= 1'b0;
      latch_only_load_ff   <= 1'b0;
      free_ff   <= 1'b0;
      err_ff    <= 1'b0;
      program_erase_enable_ff   <= 1'b0;
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      adrl_ff   <= `NPE_RST_BYTE;
      adrh_ff   <= 7'h00;
      datl_ff   <= `NPE_RST_BYTE;
      dath_ff   <= 6'h00;
      ul_ff     <= UL_IDLE;
      ws_ff     <= WS_IDLE;
      irqst_ff  <= 2'b00;
      irqmsk_ff <= 2'b00;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_space <= `NPE_SP_EE;
      mem_op    <= `NPE_OP_LATCH;
      prdata    <= 32'h0000_0000;
    end else begin
      pgd_ff    <= nxt_pgd;
      cfg_ff    <= nxt_cfg;
      latch_only_load_ff   <= nxt_latch_only_load;
      free_ff   <= nxt_free;
      err_ff    <= nxt_err;
      program_erase_enable_ff   <= nxt_program_erase_enable;
      wr_ff     <= nxt_wr;
      rd_ff     <= nxt_rd;
      adrl_ff   <= nxt_adrl;
      adrh_ff   <= nxt_adrh;
      datl_ff   <= nxt_datl;
      dath_ff   <= nxt_dath;
      ul_ff     <= nxt_ul;
      ws_ff     <= nxt_ws;
      irqst_ff  <= nxt_irqst;
      irqmsk_ff <= nxt_irqmsk;
      mem_rd    <= nxt_mem_rd;
      mem_wr    <= nxt_mem_wr;
      mem_space <= nxt_space;
      mem_op    <= nxt_op;
      prdata    <= nxt_prdata;
    end
  end

endmodule
`default_nettype wire

// ===== npe_map.vh
// Purpose: constants for the nvm program/erase control block
// Assumes: APB word offsets, registers of up to 8 bits in the low byte
// Notes:   included by npe_ctrl.v, the checker and the bench
// What this block does
// RULE1: program-select bit set routes operations to program flash, clear to eeprom.
// RULE2: config-select bit set routes operations to config, user id, device id words.
// RULE3: flash/config with latch-only set: write strobe loads latches, no programming.
// RULE4: flash/config with latch-only clear: strobe loads latches then programs them.
// RULE5: eeprom selected: latch-only bit ignored, every strobe starts an eeprom write.
// RULE6: flash/config erase bit makes strobe erase; hardware clears it after erase.
// RULE7: eeprom selected: erase bit ignored, strobe does erase then write.
// RULE8: error flag set by improper or aborted sequence and by any strobe set attempt.
// RULE9: enable bit clear blocks every program and erase cycle.
// RULE10: write strobe starts self-timed operation, hardware clears it when done.
// RULE11: software can only set the write strobe; writing zero leaves it.
// RULE12: read strobe does a one-cycle read then clears itself; software only sets it.
// RULE13: software writes 55h then AAh to unlock register before setting write strobe.
// RULE14: unlock register is write-only with no storage, only watched for the pattern.
// RULE15: config read at an unreadable address clears both data registers.
// RULE16: config user ids read/write; device id and config words read-only.
// RULE17: a program memory write stalls the processor until it completes.
// RULE18: 55h, AAh and strobe set must be consecutive accesses or unlock resets.
// RULE19: eeprom write completion sets the write irq flag, raising irq if enabled.
`ifndef NPE_MAP_VH
`define NPE_MAP_VH
// register byte offsets
`define NPE_OFF_CTRL   8'h00
`define NPE_OFF_UNLOCK 8'h04
`define NPE_OFF_ADRL   8'h08
`define NPE_OFF_ADRH   8'h0C
`define NPE_OFF_DATL   8'h10
`define NPE_OFF_DATH   8'h14
`define NPE_OFF_IRQST  8'h18
`define NPE_OFF_IRQMSK 8'h1C
// control bit positions
`define NPE_B_PGD  7
`define NPE_B_CFG  6
`define NPE_B_LATCH_ONLY_LOAD 5
`define NPE_B_FREE 4
`define NPE_B_ERR  3
`define NPE_B_PROGRAM_ERASE_ENABLE 2
`define NPE_B_WR   1
`define NPE_B_RD   0
// irq status bit positions
`define NPE_I_WDONE 0
`define NPE_I_ERR   1
// unlock pattern
`define NPE_KEY1 8'h55
`define NPE_KEY2 8'hAA
// memory space codes
`define NPE_SP_EE  2'h0
`define NPE_SP_PGM 2'h1
`define NPE_SP_CFG 2'h2
// memory operation codes
`define NPE_OP_LATCH  2'h0
`define NPE_OP_PROG   2'h1
`define NPE_OP_ERASE  2'h2
`define NPE_OP_EEWR   2'h3
// config space address limits
`define NPE_CFG_UID_LO 15'h0000
`define NPE_CFG_UID_HI 15'h0003
`define NPE_CFG_RD_LO  15'h0006
`define NPE_CFG_RD_HI  15'h0008
// reset values
`define NPE_RST_CTRL 8'h00
`define NPE_RST_BYTE 8'h00
`endif

// ===== npe_mem_model.sv
// Purpose: array-side model for npe_ctrl
// Assumes: one done pulse per write request
// Notes:   slow and fail_req come from the bench
`timescale 1ns/10ps
`default_nettype none
module npe_mem_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // requests
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [14:0] mem_addr,
  // bench controls
  input  wire logic        slow,
  input  wire logic        fail_req,
  // answers
  output logic      [13:0] mem_rdata,
  output logic             mem_done,
  output logic             mem_fail
);
  logic [5:0]  cnt_ff;
  logic [13:0] junk_ff;
  // data only with the request, noise otherwise
  assign mem_rdata = mem_rd ? (mem_addr[13:0] ^ 14'h2a5b) : junk_ff;
  // self-timed write: count down, then one done pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff   <= 6'h00;
      junk_ff  <= 14'h0000;
      mem_done <= 1'b0;
      mem_fail <= 1'b0;
    end else begin
      junk_ff  <= ~junk_ff;
      mem_done <= (cnt_ff == 6'h01);
      mem_fail <= (cnt_ff == 6'h01) && fail_req;
      if (mem_wr)
        cnt_ff <= slow ? 6'h28 : 6'h04;
      else if (cnt_ff != 6'h00)
        cnt_ff <= cnt_ff - 6'h01;
    end
  end
endmodule
`default_nettype wire

// ===== npe_ctrl_checker.sv
// Purpose: port-level assertions for npe_ctrl
// Assumes: single pclk domain
// Notes:   bound to every npe_ctrl instance
`timescale 1ns/10ps
`default_nettype none
`include "npe_map.vh"
module npe_ctrl_checker #(
  parameter int AW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          mem_rd,
  input wire logic          mem_wr,
  input wire logic [1:0]    mem_space,
  input wire logic [1:0]    mem_op,
  input wire logic [14:0]   mem_addr,
  input wire logic [13:0]   mem_wdata,
  input wire logic [13:0]   mem_rdata,
  input wire logic          mem_done,
  input wire logic          mem_fail,
  input wire logic          cpu_stall,
  input wire logic          irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ctl;
  // completed control register write
  assign wr_ctl = psel && penable && pwrite && (paddr == AW'(`NPE_OFF_CTRL));
  a_rd_pulse: assert property (mem_rd |=> !mem_rd)
    else $error("read request longer than one cycle");
  a_rd_cause: assert property ($rose(mem_rd) |-> $past(wr_ctl && pwdata[0]))
    else $error("read request without read strobe");
  a_wr_cause: assert property (mem_wr |-> $past(wr_ctl && pwdata[1] && pwdata[2], 2))
    else $error("write request without enabled strobe");
  a_refuse_off: assert property (wr_ctl && pwdata[1] && !pwdata[2] |=> !mem_wr [*3])
    else $error("write issued with enable clear");
  a_stall_hold: assert property (cpu_stall && !mem_done |=> cpu_stall)
    else $error("stall dropped before done");
  a_done_clears: assert property (cpu_stall && mem_done |=> !cpu_stall)
    else $error("stall kept after done");
  a_ee_both: assert property (mem_wr && mem_space == `NPE_SP_EE |-> mem_op == `NPE_OP_EEWR)
    else $error("eeprom write without erase and write");
  a_stall_start: assert property ($rose(cpu_stall) |=> mem_wr && mem_space != `NPE_SP_EE)
    else $error("stall without program space write request");
  a_unlock_zero: assert property (psel && penable && !pwrite
    && paddr == AW'(`NPE_OFF_UNLOCK) |-> prdata == 32'h0000_0000)
    else $error("unlock register read not zero");
endmodule
bind npe_ctrl npe_ctrl_checker #(.AW(AW)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_rd, .mem_wr, .mem_space, .mem_op,
  .mem_addr, .mem_wdata, .mem_rdata, .mem_done, .mem_fail, .cpu_stall, .irq);
`default_nettype wire

// ===== tb_npe_ctrl.sv
// Purpose: self-checking bench for npe_ctrl
// Assumes: zero-wait apb slave, array model beside it
// Notes:   strobes are polled through the control register
`timescale 1ns/10ps
`default_nettype none
`include "npe_map.vh"
module tb_npe_ctrl;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        mem_rd, mem_wr, mem_done, mem_fail, cpu_stall, irq;
  logic        slow, fail_req, err;
  logic [7:0]  paddr, rd;
  logic [31:0] pwdata, prdata;
  logic [1:0]  mem_space, mem_op, op_seen, sp_seen;
  logic [14:0] mem_addr;
  logic [13:0] mem_rdata, mem_wdata, wd_seen;
  int          nwr, bad_count, checks_done;
  localparam logic [7:0] oc = `NPE_OFF_CTRL;
  localparam logic [7:0] ou = `NPE_OFF_UNLOCK;
  localparam logic [7:0] oal = `NPE_OFF_ADRL;
  localparam logic [7:0] oah = `NPE_OFF_ADRH;
  localparam logic [7:0] odl = `NPE_OFF_DATL;
  localparam logic [7:0] odh = `NPE_OFF_DATH;
  localparam logic [7:0] ost = `NPE_OFF_IRQST;
  localparam logic [7:0] omk = `NPE_OFF_IRQMSK;
  npe_ctrl #(.AW(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_space(mem_space),
    .mem_op(mem_op), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_done(mem_done), .mem_fail(mem_fail), .cpu_stall(cpu_stall), .irq(irq));
  npe_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .slow(slow), .fail_req(fail_req), .mem_rdata(mem_rdata),
    .mem_done(mem_done), .mem_fail(mem_fail));
  // clock
  always #12.5 pclk = ~pclk;
  // record what the array was asked to do
  always @(posedge pclk) begin
    if (mem_wr) begin
      nwr     <= nwr + 1;
      op_seen <= mem_op;
      wd_seen <= mem_wdata;
    end
    if (mem_wr || mem_rd)
      sp_seen <= mem_space;
  end
  // one apb transfer, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ulk();
    bus(1'b1, ou, 8'h55);
    bus(1'b1, ou, 8'haa);
  endtask
  // poll until the write strobe drops
  task automatic wt();
    int n;
    n = 0;
    bus(1'b0, oc, 8'h00);
    while (rd[1] !== 1'b0 && n < 200) begin
      bus(1'b0, oc, 8'h00);
      n++;
    end
    chk("wr_done", 8'h00, rd & 8'h02);
  endtask
  task automatic t_regs();
    bus(1'b0, oc, 8'h00);
    chk("ctrl_rst", 8'h00, rd);
    bus(1'b1, ou, 8'h5a);
    bus(1'b0, ou, 8'h00);
    chk("unlock_rd", 8'h00, rd);
    bus(1'b0, 8'h40, 8'h00);
    chk("slverr", 8'h01, {7'h00, err});
  endtask
  task automatic t_read();
    logic [13:0] x;
    x = 14'h1234 ^ 14'h2a5b;
    bus(1'b1, oal, 8'h34);
    bus(1'b1, oah, 8'h12);
    bus(1'b1, oc, 8'h81);
    bus(1'b0, oc, 8'h00);
    chk("rd_clr", 8'h80, rd);
    chk("sp_pgm", {6'h00, `NPE_SP_PGM}, {6'h00, sp_seen});
    bus(1'b0, odl, 8'h00);
    chk("datl", x[7:0], rd);
    bus(1'b0, odh, 8'h00);
    chk("dath", {2'b00, x[13:8]}, rd);
    bus(1'b1, oal, 8'h04);
    bus(1'b1, oah, 8'h00);
    bus(1'b1, oc, 8'h41);
    bus(1'b0, odl, 8'h00);
    chk("cfg_gap", 8'h00, rd);
    bus(1'b1, oal, 8'h06);
    bus(1'b1, oc, 8'h41);
    bus(1'b0, odl, 8'h00);
    chk("cfg_id", 8'h06 ^ 8'h5b, rd);
  endtask
  task automatic t_ewr();
    bus(1'b1, omk, 8'h03);
    bus(1'b0, ost, 8'h00);
    bus(1'b1, odl, 8'hc3);
    bus(1'b1, odh, 8'h15);
    // space and mode come from the stored control bits
    bus(1'b1, oc, 8'h34);
    ulk();
    bus(1'b1, oc, 8'h36);
    wt();
    chk("ee_op", {6'h00, `NPE_OP_EEWR}, {6'h00, op_seen});
    chk("sp_ee", {6'h00, `NPE_SP_EE}, {6'h00, sp_seen});
    chk("wdata_lo", 8'hc3, wd_seen[7:0]);
    chk("wdata_hi", 8'h15, {2'b00, wd_seen[13:8]});
    chk("ee_err", 8'h00, rd & 8'h08);
    chk("irq_on", 8'h01, {7'h00, irq});
    bus(1'b0, ost, 8'h00);
    chk("irq_st", 8'h01, rd);
    chk("irq_off", 8'h00, {7'h00, irq});
  endtask
  task automatic t_lock();
    int n0;
    n0 = nwr;
    bus(1'b1, oc, 8'h86);
    bus(1'b0, oc, 8'h00);
    chk("nolock", 8'h08, rd & 8'h0a);
    ulk();
    bus(1'b1, oc, 8'h82);
    bus(1'b1, ou, 8'h55);
    bus(1'b0, oc, 8'h00);
    bus(1'b1, ou, 8'haa);
    bus(1'b1, oc, 8'h86);
    // select config space first so the strobe sees it
    bus(1'b1, oc, 8'h44);
    ulk();
    bus(1'b1, oc, 8'h46);
    bus(1'b0, oc, 8'h00);
    chk("refused", n0[7:0], nwr[7:0]);
    bus(1'b0, ost, 8'h00);
    chk("irq_err", 8'h02, rd);
  endtask
  task automatic t_flash();
    logic [7:0] v [3] = '{8'ha6, 8'h86, 8'h96};
    logic [1:0] e [3] = '{`NPE_OP_LATCH, `NPE_OP_PROG, `NPE_OP_ERASE};
    slow <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      // mode bits are taken from the stored register at the strobe
      bus(1'b1, oc, v[i] & 8'hfd);
      ulk();
      bus(1'b1, oc, v[i]);
      chk("stall", 8'h01, {7'h00, cpu_stall});
      bus(1'b1, oc, v[i] & 8'hfd);
      bus(1'b0, oc, 8'h00);
      chk("wr_held", 8'h02, rd & 8'h02);
      wt();
      chk("op", {6'h00, e[i]}, {6'h00, op_seen});
      chk("done_bits", 8'h00, rd & 8'h1a);
    end
    slow <= 1'b0;
  endtask
  task automatic t_fail();
    fail_req <= 1'b1;
    bus(1'b1, oc, 8'h84);
    ulk();
    bus(1'b1, oc, 8'h86);
    wt();
    chk("fail_err", 8'h08, rd & 8'h0a);
    bus(1'b0, ost, 8'h00);
    chk("fail_irq", 8'h02, rd);
    fail_req <= 1'b0;
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    slow = 1'b0;
    fail_req = 1'b0;
    nwr = 0;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_read();
    t_ewr();
    t_lock();
    t_flash();
    t_fail();
    stop_test();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
